// ==== cld_params.svh ====
// Constants for the character LCD instruction decoder
`ifndef CLD_PARAMS_SVH
`define CLD_PARAMS_SVH
`define CLD_CLK_NS        4
`define CLD_T_DATA_NS     18500
`define CLD_T_LONG_NS     760000
`define CLD_T_BLINK_NS    185000000
`define CLD_FIFO_DEPTH    4
`define CLD_SPACE_CODE    8'h20
`define CLD_AC_ZERO       7'h00
`define CLD_L1_END        7'h27
`define CLD_L2_START      7'h40
`define CLD_L2_END        7'h67
`define CLD_1L_END        7'h4F
`define CLD_FILL_LAST     7'h7F
`define CLD_OPB_DDADDR    7
`define CLD_OPB_CGADDR    6
`define CLD_OPB_FUNC      5
`define CLD_OPB_SHIFT     4
`define CLD_OPB_DISPLAY   3
`define CLD_OPB_ENTRY     2
`define CLD_OPB_HOME      1
`define CLD_OPB_CLEAR     0
`define CLD_B_IDDIR       1
`define CLD_B_AUTOSHIFT   0
`define CLD_B_PANEL       2
`define CLD_B_CURSOR      1
`define CLD_B_BLINK       0
`define CLD_B_TARGET      3
`define CLD_B_MOVEDIR     2
`define CLD_B_DL          4
`define CLD_B_N           3
`define CLD_B_F           2
`define CLD_RST_BUS_WIDTH 1'b1
`define CLD_RST_LINES     1'b0
`define CLD_RST_FONT      1'b0
`define CLD_RST_PANEL     1'b0
`define CLD_RST_CURSOR    1'b0
`define CLD_RST_BLINK     1'b0
`define CLD_RST_ADDR_DIR  1'b1
`define CLD_RST_AUTOSHIFT 1'b0
`endif

// ==== cld_pkg.sv ====
// Types shared by the character LCD instruction decoder
`default_nettype none
package cld_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_EXEC} cld_state_t;
	typedef enum logic [3:0] {OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISPLAY, OP_SHIFT, OP_FUNC, OP_CGADDR,
		OP_DDADDR} cld_op_t;
	typedef struct packed {
		logic       e;
		logic       rs;
		logic       rw;
		logic [7:0] db;
	} cld_pin_t;
	typedef struct packed {
		logic       rs;
		logic       rw;
		logic [7:0] data;
	} cld_cmd_t;
endpackage
`default_nettype wire

// ==== cld_decoder.sv ====
// Instruction decoder, address counter and command FIFO of a character LCD controller
`timescale 1ns/1ps
`default_nettype none
`include "cld_params.svh"

module cld_fifo
#(
	parameter int W     = 10,
	parameter int DEPTH = `CLD_FIFO_DEPTH
)
(
	input  wire logic         mclk_in,
	input  wire logic         rst_b_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic          push;
	logic          pop;

	assign in_ready_out  = (count_r != FULL);
	assign out_valid_out = (count_r != '0);
	assign out_data_out  = mem_r[rd_ptr_r];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	always_ff @(posedge mclk_in)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_in;
	end

	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule

module cld_decoder
#(
	parameter int unsigned DATA_CYC   = (`CLD_T_DATA_NS + `CLD_CLK_NS - 1) / `CLD_CLK_NS,
	parameter int unsigned LONG_CYC   = (`CLD_T_LONG_NS + `CLD_CLK_NS - 1) / `CLD_CLK_NS,
	parameter int unsigned BLINK_CYC  = `CLD_T_BLINK_NS / `CLD_CLK_NS,
	parameter int          FIFO_DEPTH = `CLD_FIFO_DEPTH
)
(
	input  wire logic       mclk_in,
	input  wire logic       rst_b_in,
	input  wire logic       bus_strobe_in,
	input  wire logic       command_data_select_in,
	input  wire logic       direction_sel_in,
	input  wire logic [7:0] db_in,
	output logic      [7:0] db_out,
	output logic            db_oe_out,
	output logic            busy_indicator_out,
	output logic            cmd_ready_out,
	output logic      [6:0] address_counter_out,
	output logic            glyph_sel_out,
	output logic            panel_on_out,
	output logic            cursor_on_out,
	output logic            cursor_blink_out,
	output logic            cursor_cell_lit_out,
	output logic            addr_dir_out,
	output logic            autoshift_en_out,
	output logic            bus_width_sel_out,
	output logic            line_count_sel_out,
	output logic            tall_font_out,
	output logic      [6:0] shift_offset_out,
	input  wire logic [6:0] scan_addr_in,
	output logic      [7:0] scan_data_out
);
	localparam int unsigned BLINK_HALF = BLINK_CYC / 2;

	cld_pkg::cld_pin_t   pin_meta_r;
	cld_pkg::cld_pin_t   pin_r;
	logic                e_prev_r;
	logic                nib_phase_r;
	logic [3:0]          hi_nib_r;
	logic                xfer_done;
	logic [7:0]          xfer_byte;
	cld_pkg::cld_cmd_t   push_cmd;
	logic                push_valid;
	cld_pkg::cld_cmd_t   cmd;
	logic                cmd_valid;
	logic                pop;
	cld_pkg::cld_op_t    op;
	cld_pkg::cld_state_t state_r;
	logic [31:0]         cnt_r;
	logic [6:0]          fill_idx_r;
	logic [6:0]          ac_r;
	logic                glyph_sel_r;
	logic                addr_dir_r;
	logic                autoshift_r;
	logic                panel_on_r;
	logic                cursor_on_r;
	logic                blink_r;
	logic                bus_width_r;
	logic                lines_r;
	logic                font_r;
	logic [6:0]          shift_r;
	logic [31:0]         blink_cnt_r;
	logic                blink_phase_r;
	logic [7:0]          disp_mem [128];
	logic [7:0]          glyph_mem [64];
	logic [7:0]          rd_data_r;
	logic                data_wr;
	logic                data_rd;

	function automatic cld_pkg::cld_op_t decode_op(input logic [7:0] b);
		if (b[`CLD_OPB_DDADDR])       return cld_pkg::OP_DDADDR;
		else if (b[`CLD_OPB_CGADDR])  return cld_pkg::OP_CGADDR;
		else if (b[`CLD_OPB_FUNC])    return cld_pkg::OP_FUNC;
		else if (b[`CLD_OPB_SHIFT])   return cld_pkg::OP_SHIFT;
		else if (b[`CLD_OPB_DISPLAY]) return cld_pkg::OP_DISPLAY;
		else if (b[`CLD_OPB_ENTRY])   return cld_pkg::OP_ENTRY;
		else if (b[`CLD_OPB_HOME])    return cld_pkg::OP_HOME;
		else if (b[`CLD_OPB_CLEAR])   return cld_pkg::OP_CLEAR;
		else                          return cld_pkg::OP_NONE;
	endfunction

	// Step the counter with line wrap; glyph addresses wrap within six bits
	function automatic logic [6:0] next_ac(input logic [6:0] a, input logic inc, input logic two, input logic gly);
		if (gly)
			return {1'b0, inc ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
		else if (two && inc)
			return (a == `CLD_L1_END) ? `CLD_L2_START : (a >= `CLD_L2_END) ? `CLD_AC_ZERO : a + 7'h01;
		else if (two)
			return (a == `CLD_L2_START) ? `CLD_L1_END : (a == `CLD_AC_ZERO) ? `CLD_L2_END : a - 7'h01;
		else if (inc)
			return (a >= `CLD_1L_END) ? `CLD_AC_ZERO : a + 7'h01;
		else
			return (a == `CLD_AC_ZERO) ? `CLD_1L_END : a - 7'h01;
	endfunction

	// One offset for the whole panel, so every line moves at once
	function automatic logic [6:0] next_shift(input logic [6:0] s, input logic left, input logic two);
		logic [6:0] top;
		top = two ? `CLD_L1_END : `CLD_1L_END;
		if (left)
			return (s >= top) ? `CLD_AC_ZERO : s + 7'h01;
		else
			return (s == `CLD_AC_ZERO) ? top : s - 7'h01;
	endfunction

	// Strobe, select lines and data bus come from the host's domain
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pin_meta_r <= '0;
			pin_r      <= '0;
			e_prev_r   <= 1'b0;
		end
		else
		begin
			pin_meta_r <= {bus_strobe_in, command_data_select_in, direction_sel_in, db_in};
			pin_r      <= pin_meta_r;
			e_prev_r   <= pin_r.e;
		end
	end

	// Transfers complete on the strobe's falling edge
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			nib_phase_r <= 1'b0;
			hi_nib_r    <= 4'h0;
		end
		else if (e_prev_r && !pin_r.e && !bus_width_r)
		begin
			nib_phase_r <= ~nib_phase_r;
			if (!nib_phase_r)
				hi_nib_r <= pin_r.db[7:4];
		end
	end

	assign xfer_done  = e_prev_r && !pin_r.e && (bus_width_r || nib_phase_r);
	assign xfer_byte  = bus_width_r ? pin_r.db : {hi_nib_r, pin_r.db[7:4]};
	assign push_cmd   = '{rs: pin_r.rs, rw: pin_r.rw, data: xfer_byte};
	// Status reads bypass the queue and cost no execution time
	assign push_valid = xfer_done && (pin_r.rs || !pin_r.rw);

	// A host that ignores busy fills this queue; once full, further transfers are lost
	cld_fifo #(.W($bits(cld_pkg::cld_cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.mclk_in       (mclk_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (push_valid),
		.in_ready_out  (cmd_ready_out),
		.in_data_in    (push_cmd),
		.out_valid_out (cmd_valid),
		.out_ready_in  (state_r == cld_pkg::ST_IDLE),
		.out_data_out  (cmd)
	);

	assign pop     = cmd_valid && (state_r == cld_pkg::ST_IDLE);
	assign op      = decode_op(cmd.data);
	assign data_wr = pop && cmd.rs && !cmd.rw;
	assign data_rd = pop && cmd.rs && cmd.rw;

	// Execution timer; power-on runs a clear first
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_r    <= cld_pkg::ST_CLEAR;
			cnt_r      <= LONG_CYC - 1;
			fill_idx_r <= `CLD_AC_ZERO;
		end
		else
		begin
			case (state_r)
				cld_pkg::ST_IDLE:
				begin
					fill_idx_r <= `CLD_AC_ZERO;
					if (pop && !cmd.rs && op == cld_pkg::OP_CLEAR)
					begin
						state_r <= cld_pkg::ST_CLEAR;
						cnt_r   <= LONG_CYC - 1;
					end
					else if (pop)
					begin
						state_r <= cld_pkg::ST_EXEC;
						cnt_r   <= (!cmd.rs && op == cld_pkg::OP_HOME) ? LONG_CYC - 1 : DATA_CYC - 1;
					end
				end
				cld_pkg::ST_CLEAR:
				begin
					cnt_r      <= cnt_r - 1;
					fill_idx_r <= fill_idx_r + 7'h01;
					if (fill_idx_r == `CLD_FILL_LAST)
						state_r <= cld_pkg::ST_EXEC;
				end
				cld_pkg::ST_EXEC:
				begin
					if (cnt_r == 0)
						state_r <= cld_pkg::ST_IDLE;
					else
						cnt_r <= cnt_r - 1;
				end
				default:
					state_r <= cld_pkg::ST_IDLE;
			endcase
		end
	end

	assign busy_indicator_out = (state_r != cld_pkg::ST_IDLE) || cmd_valid;

	// Address counter and memory select
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ac_r        <= `CLD_AC_ZERO;
			glyph_sel_r <= 1'b0;
		end
		else if (pop && cmd.rs)
			ac_r <= next_ac(ac_r, addr_dir_r, lines_r, glyph_sel_r);
		else if (pop)
		begin
			case (op)
				cld_pkg::OP_CLEAR, cld_pkg::OP_HOME:
				begin
					ac_r        <= `CLD_AC_ZERO;
					glyph_sel_r <= 1'b0;
				end
				cld_pkg::OP_SHIFT:
					if (!cmd.data[`CLD_B_TARGET])
						ac_r <= next_ac(ac_r, cmd.data[`CLD_B_MOVEDIR], lines_r, 1'b0);
				cld_pkg::OP_CGADDR:
				begin
					ac_r        <= {1'b0, cmd.data[5:0]};
					glyph_sel_r <= 1'b1;
				end
				cld_pkg::OP_DDADDR:
				begin
					ac_r        <= cmd.data[6:0];
					glyph_sel_r <= 1'b0;
				end
				default:
					ac_r <= ac_r;
			endcase
		end
	end

	// Mode settings, defaults as after power-on
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			addr_dir_r  <= `CLD_RST_ADDR_DIR;
			autoshift_r <= `CLD_RST_AUTOSHIFT;
			panel_on_r  <= `CLD_RST_PANEL;
			cursor_on_r <= `CLD_RST_CURSOR;
			blink_r     <= `CLD_RST_BLINK;
			bus_width_r <= `CLD_RST_BUS_WIDTH;
			lines_r     <= `CLD_RST_LINES;
			font_r      <= `CLD_RST_FONT;
		end
		else if (pop && !cmd.rs)
		begin
			case (op)
				cld_pkg::OP_CLEAR:
					addr_dir_r <= 1'b1;
				cld_pkg::OP_ENTRY:
				begin
					addr_dir_r  <= cmd.data[`CLD_B_IDDIR];
					autoshift_r <= cmd.data[`CLD_B_AUTOSHIFT];
				end
				cld_pkg::OP_DISPLAY:
				begin
					panel_on_r  <= cmd.data[`CLD_B_PANEL];
					cursor_on_r <= cmd.data[`CLD_B_CURSOR];
					blink_r     <= cmd.data[`CLD_B_BLINK];
				end
				cld_pkg::OP_FUNC:
				begin
					bus_width_r <= cmd.data[`CLD_B_DL];
					lines_r     <= cmd.data[`CLD_B_N];
					font_r      <= cmd.data[`CLD_B_F];
				end
				default:
					font_r <= font_r;
			endcase
		end
	end

	// Display shift offset
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			shift_r <= `CLD_AC_ZERO;
		else if (pop && !cmd.rs && (op == cld_pkg::OP_CLEAR || op == cld_pkg::OP_HOME))
			shift_r <= `CLD_AC_ZERO;
		else if (pop && !cmd.rs && op == cld_pkg::OP_SHIFT && cmd.data[`CLD_B_TARGET])
			shift_r <= next_shift(shift_r, !cmd.data[`CLD_B_MOVEDIR], lines_r);
		else if (data_wr && autoshift_r && !glyph_sel_r)
			shift_r <= next_shift(shift_r, addr_dir_r, lines_r);
	end

	// Memories; the clear fill owns the display array while it runs
	always_ff @(posedge mclk_in)
	begin
		if (state_r == cld_pkg::ST_CLEAR)
			disp_mem[fill_idx_r] <= `CLD_SPACE_CODE;
		else if (data_wr && !glyph_sel_r)
			disp_mem[ac_r] <= cmd.data;
		if (data_wr && glyph_sel_r)
			glyph_mem[ac_r[5:0]] <= cmd.data;
	end

	// Prefetch tracks the counter, so a read right after a write returns the next cell
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rd_data_r     <= 8'h00;
			scan_data_out <= 8'h00;
		end
		else
		begin
			rd_data_r     <= glyph_sel_r ? glyph_mem[ac_r[5:0]] : disp_mem[ac_r];
			scan_data_out <= disp_mem[scan_addr_in];
		end
	end

	// Read bus; nibble reads show high half then low half on the upper lines
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			db_out    <= 8'h00;
			db_oe_out <= 1'b0;
		end
		else
		begin
			db_oe_out <= pin_r.e && pin_r.rw;
			if (bus_width_r)
				db_out <= pin_r.rs ? rd_data_r : {busy_indicator_out, ac_r};
			else if (!nib_phase_r)
				db_out <= {pin_r.rs ? rd_data_r[7:4] : {busy_indicator_out, ac_r[6:4]}, 4'h0};
			else
				db_out <= {pin_r.rs ? rd_data_r[3:0] : ac_r[3:0], 4'h0};
		end
	end

	// Blink phase toggles every half period
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			blink_cnt_r         <= '0;
			blink_phase_r       <= 1'b0;
			cursor_cell_lit_out <= 1'b0;
		end
		else
		begin
			if (!blink_r)
			begin
				blink_cnt_r   <= '0;
				blink_phase_r <= 1'b0;
			end
			else if (blink_cnt_r >= BLINK_HALF - 1)
			begin
				blink_cnt_r   <= '0;
				blink_phase_r <= ~blink_phase_r;
			end
			else
				blink_cnt_r <= blink_cnt_r + 1;
			cursor_cell_lit_out <= panel_on_r && blink_r && blink_phase_r;
		end
	end

	assign address_counter_out = ac_r;
	assign glyph_sel_out       = glyph_sel_r;
	assign panel_on_out        = panel_on_r;
	assign cursor_on_out       = cursor_on_r;
	assign cursor_blink_out    = blink_r;
	assign addr_dir_out        = addr_dir_r;
	assign autoshift_en_out    = autoshift_r;
	assign bus_width_sel_out   = bus_width_r;
	assign line_count_sel_out  = lines_r;
	assign tall_font_out       = font_r && !lines_r;
	assign shift_offset_out    = shift_r;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	property p_status_bypass;
		xfer_done && !pin_r.rs && pin_r.rw |-> !push_valid;
	endproperty
	a_status_bypass: assert property (p_status_bypass) else $error("status read entered queue");

	property p_busy_hold;
		pop && cmd.rs |=> busy_indicator_out [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

	property p_ddaddr;
		pop && !cmd.rs && op == cld_pkg::OP_DDADDR |=> ac_r == $past(cmd.data[6:0]) && !glyph_sel_r;
	endproperty
	a_ddaddr: assert property (p_ddaddr) else $error("display address set wrong");

	property p_cgaddr;
		pop && !cmd.rs && op == cld_pkg::OP_CGADDR |=> ac_r == {1'b0, $past(cmd.data[5:0])} && glyph_sel_r;
	endproperty
	a_cgaddr: assert property (p_cgaddr) else $error("glyph address set wrong");

	// Below the first line end no wrap applies in either line mode
	property p_inc;
		data_wr && addr_dir_r && !glyph_sel_r && ac_r < `CLD_L1_END |=> ac_r == $past(ac_r) + 7'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("counter did not increment");

	property p_clear;
		pop && !cmd.rs && op == cld_pkg::OP_CLEAR |=> ac_r == `CLD_AC_ZERO && addr_dir_r ##128 busy_indicator_out;
	endproperty
	a_clear: assert property (p_clear) else $error("clear result wrong");

	property p_home;
		pop && !cmd.rs && op == cld_pkg::OP_HOME |=> ac_r == `CLD_AC_ZERO && shift_r == `CLD_AC_ZERO;
	endproperty
	a_home: assert property (p_home) else $error("home result wrong");

	property p_no_shift;
		pop && (cmd.rw || glyph_sel_r || !autoshift_r) && cmd.rs |=> $stable(shift_r);
	endproperty
	a_no_shift: assert property (p_no_shift) else $error("display shifted on access");

	property p_disp_shift;
		pop && !cmd.rs && op == cld_pkg::OP_SHIFT && cmd.data[`CLD_B_TARGET] |=> $stable(ac_r);
	endproperty
	a_disp_shift: assert property (p_disp_shift) else $error("counter moved on display shift");

	property p_first_nibble;
		e_prev_r && !pin_r.e && !bus_width_r && !nib_phase_r |-> !push_valid;
	endproperty
	a_first_nibble: assert property (p_first_nibble) else $error("first nibble completed a transfer");

	property p_blank;
		!panel_on_r |=> !cursor_cell_lit_out;
	endproperty
	a_blank: assert property (p_blank) else $error("cursor lit while blanked");

	property p_oe_read;
		pin_r.e && pin_r.rw |=> db_oe_out;
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("read bus not driven");

	c_write: cover property (data_wr && !glyph_sel_r);
	c_nibble_read: cover property (xfer_done && !bus_width_r && pin_r.rs && pin_r.rw);
	c_fifo_full: cover property (!cmd_ready_out);
	c_wrap: cover property (data_wr && lines_r && ac_r == `CLD_L1_END);
endmodule
`default_nettype wire

// ==== cld_host_model.sv ====
// Host processor model driving the parallel instruction bus
`timescale 1ns/1ps
`default_nettype none
module cld_host_model
(
	input  wire logic       mclk_in,
	input  wire logic [7:0] rd_in,
	output logic            strobe_out,
	output logic            rs_out,
	output logic            rw_out,
	output logic      [7:0] db_out
);
	logic nib4 = 1'b0;
	initial
	begin
		strobe_out = 1'b0;
		rs_out = 1'b0;
		rw_out = 1'b0;
		db_out = 8'h00;
	end
	// Strobe four clocks high then four low; data held past the synchroniser delay
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk_in);
		rs_out <= rs;
		rw_out <= rw;
		db_out <= rw ? ~db_out : d;
		strobe_out <= 1'b1;
		repeat (4) @(posedge mclk_in);
		q = rd_in;
		strobe_out <= 1'b0;
		repeat (4) @(posedge mclk_in);
		// A released bus must not keep looking like the last byte
		db_out <= ~db_out;
	endtask
	task automatic access(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] hi;
		logic [7:0] lo;
		if (nib4)
		begin
			xfer(rs, rw, d, hi);
			xfer(rs, rw, {d[3:0], 4'h0}, lo);
			q = {hi[7:4], lo[7:4]};
		end
		else
			xfer(rs, rw, d, q);
	endtask
	task automatic wait_ready(output logic ok);
		logic [7:0] s;
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++)
		begin
			access(1'b0, 1'b1, 8'h00, s);
			ok = (s[7] === 1'b0);
		end
	endtask
endmodule
`default_nettype wire

// ==== test_cld_decoder.sv ====
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module test_cld_decoder;
	typedef struct packed {
		logic [7:0]  op;
		logic [15:0] exp;
	} cld_row_t;
	logic        mclk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic  [6:0] scan_addr_in = 7'h00;
	logic        e, rs, rw, oe, busy, rdy_o, glyph, panel, cur, blink, lit, dir, ash, bw, lines, tall;
	logic  [7:0] db, dq, sd, q;
	logic  [6:0] ac, offs;
	int          mismatches = 0;
	int          n_compared = 0;
	int          nh, nl;
	wire logic [15:0] st = {glyph, panel, cur, blink, dir, ash, bw, lines, tall, ac};
	cld_row_t    rows [13] = '{'{8'h85, 16'h0A05}, '{8'h52, 16'h8A12}, '{8'h0F, 16'hFA12}, '{8'h0C, 16'hCA12},
		'{8'h05, 16'hC612}, '{8'h06, 16'hCA12}, '{8'h34, 16'hCA92}, '{8'h38, 16'hCB12}, '{8'h3C, 16'hCB12},
		'{8'hA7, 16'h4B27}, '{8'h14, 16'h4B40}, '{8'h10, 16'h4B27}, '{8'h04, 16'h4327}};
	always #2 mclk_in = ~mclk_in;
	cld_host_model u_host (.mclk_in(mclk_in), .rd_in(dq), .strobe_out(e), .rs_out(rs), .rw_out(rw), .db_out(db));
	cld_decoder #(.DATA_CYC(10), .LONG_CYC(200), .BLINK_CYC(20)) u_dut (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus_strobe_in(e), .command_data_select_in(rs),
		.direction_sel_in(rw), .db_in(db), .db_out(dq), .db_oe_out(oe), .busy_indicator_out(busy),
		.cmd_ready_out(rdy_o), .address_counter_out(ac), .glyph_sel_out(glyph), .panel_on_out(panel),
		.cursor_on_out(cur), .cursor_blink_out(blink), .cursor_cell_lit_out(lit), .addr_dir_out(dir),
		.autoshift_en_out(ash), .bus_width_sel_out(bw), .line_count_sel_out(lines), .tall_font_out(tall),
		.shift_offset_out(offs), .scan_addr_in(scan_addr_in), .scan_data_out(sd));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic rdy();
		logic ok;
		u_host.wait_ready(ok);
		check("ready", ok, 1'b1);
	endtask
	task automatic op(input logic r, input logic [7:0] d);
		u_host.access(r, 1'b0, d, q);
		rdy();
	endtask
	task automatic rdd(input logic [7:0] exp);
		u_host.access(1'b1, 1'b1, 8'h00, q);
		check("read data", q, exp);
		rdy();
	endtask
	task automatic scan(input logic [6:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		scan_addr_in <= a;
		repeat (2) @(posedge mclk_in);
		@(negedge mclk_in);
		check("scan", sd, exp);
	endtask
	initial
	begin
		repeat (30000) @(posedge mclk_in);
		mismatches++;
		complete_run();
	end
	initial
	begin
		repeat (8) @(posedge mclk_in);
		check("busy in reset", busy, 1'b1);
		check("modes in reset", st, 16'h0A00);
		check("bus off", oe, 1'b0);
		rst_b_in <= 1'b1;
		rdy();
		scan(7'h05, 8'h20);
		$display("test reset done");
		foreach (rows[i])
		begin
			op(1'b0, rows[i].op);
			check("modes", st, rows[i].exp);
		end
		$display("test rows done");
		op(1'b0, 8'h02);
		check("home", {offs, 2'b00, ac}, 16'h0000);
		op(1'b0, 8'h07);
		op(1'b1, 8'h41);
		check("autoshift write", {offs, 2'b00, ac}, 16'h0201);
		op(1'b0, 8'h06);
		op(1'b1, 8'h42);
		check("plain write", {offs, 2'b00, ac}, 16'h0202);
		scan(7'h00, 8'h41);
		scan(7'h01, 8'h42);
		op(1'b0, 8'h80);
		rdd(8'h41);
		op(1'b0, 8'h05);
		rdd(8'h42);
		check("read step", {offs, 2'b00, ac}, 16'h0200);
		op(1'b0, 8'h43);
		op(1'b1, 8'h1F);
		check("glyph write", {offs, glyph, 1'b0, ac}, 16'h0302);
		op(1'b0, 8'h43);
		rdd(8'h1F);
		op(1'b0, 8'h02);
		op(1'b0, 8'h18);
		check("display shift", {offs, 2'b00, ac}, 16'h0200);
		op(1'b0, 8'h1C);
		check("shift back", offs, 7'h00);
		op(1'b0, 8'h01);
		check("clear", {dir, ac}, 8'h80);
		scan(7'h00, 8'h20);
		u_host.access(1'b0, 1'b0, 8'h80, q);
		u_host.access(1'b0, 1'b1, 8'h00, q);
		check("status busy", q, 8'h80);
		rdy();
		$display("test data done");
		u_host.access(1'b0, 1'b0, 8'h01, q);
		for (int i = 1; i < 5; i++)
			u_host.access(1'b0, 1'b0, 8'h80 | i[7:0], q);
		check("queue full", rdy_o, 1'b0);
		u_host.access(1'b0, 1'b0, 8'h85, q);
		rdy();
		check("refused", ac, 7'h04);
		$display("test queue done");
		op(1'b0, 8'h0D);
		nh = 0;
		nl = 0;
		repeat (60) @(posedge mclk_in) if (lit === 1'b1) nh++; else nl++;
		check("blink", {nh > 0, nl > 0}, 2'b11);
		op(1'b0, 8'h09);
		nh = 0;
		repeat (60) @(posedge mclk_in) if (lit === 1'b1) nh++;
		check("blank cell", nh, 0);
		$display("test blink done");
		u_host.access(1'b0, 1'b0, 8'h28, q);
		// Polls after this must already be split, or the nibble phase drifts
		u_host.nib4 = 1'b1;
		rdy();
		check("nibble mode", bw, 1'b0);
		u_host.xfer(1'b0, 1'b0, 8'h80, q);
		check("busy after half", busy, 1'b0);
		u_host.xfer(1'b0, 1'b0, 8'h50, q);
		rdy();
		u_host.access(1'b0, 1'b1, 8'h00, q);
		check("nibble status", q, 8'h05);
		$display("test nibble done");
		complete_run();
	end
endmodule
`default_nettype wire
